//--- core/fbs_pkg.sv
/*
 * Shared constants for the fieldbus slave status indicator: codes,
 * address limits, status word layout and dwell timing.
 * Assumes a 250 MHz core clock.
 */
package fbs_pkg;
    // ---------------------------------------------------------------
    // Display and status codes
    // ---------------------------------------------------------------
    localparam logic [7:0] CODE_NONE                 = 8'h00;
    localparam logic [7:0] CODE_HOST_STOP            = 8'h80;
    localparam logic [7:0] CODE_INIT                 = 8'hc0;
    localparam logic [7:0] CODE_ADDRESS_OUT_OF_RANGE = 8'hf0;
    localparam logic [7:0] CODE_INTERNAL_HW_FAULT    = 8'hf1;
    localparam logic [7:0] CODE_PARAMETER_FAULT      = 8'hf2;
    localparam logic [7:0] CODE_CONFIGURATION_FAULT  = 8'hf3;
    localparam logic [7:0] CODE_IO_DETECT_FAULT      = 8'hf4;
    localparam logic [7:0] CODE_FACTORY_TEST         = 8'hf5;
    localparam logic [7:0] CODE_NOT_ON_NETWORK       = 8'hf6;

    // ---------------------------------------------------------------
    // Node address range and status word layout
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_MIN        = 8'h01;
    localparam logic [7:0] ADDR_MAX        = 8'h7d;
    localparam int         STAT_HI_LSB     = 8;
    localparam logic [7:0] STAT_HI_RUN     = 8'h00;
    localparam logic [7:0] STAT_LO_NORMAL  = 8'h00;
    localparam logic [15:0] STAT_RESET     = 16'h0000;
    localparam int         REG_NUM_W       = 16;

    // ---------------------------------------------------------------
    // Dwell timing
    // ---------------------------------------------------------------
    localparam int CLK_KHZ      = 250000;
    localparam int DWELL_MS     = 1000;
    localparam int DWELL_CYCLES = DWELL_MS * CLK_KHZ;

    // Display sequence position, Gray along addr -> second -> third
    typedef enum logic [1:0] {
        SLOT_ADDR   = 2'b00,
        SLOT_SECOND = 2'b01,
        SLOT_THIRD  = 2'b11
    } fbs_slot_t;

    // Valid node address test, used by core and checks
    function automatic logic fbs_addr_ok(input logic [7:0] a);
        return (a >= ADDR_MIN) && (a <= ADDR_MAX);
    endfunction
endpackage

//--- core/fbs_word_if.sv
/*
 * Carrier for the status word from the indicator core to the
 * host writer. Assumes both ends share i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
interface fbs_word_if;
    logic [15:0] word;    // Current status word
    logic        valid;   // Word meaningful (address captured)
    modport src (output word, output valid);
    modport dst (input word, input valid);
endinterface
`default_nettype wire

//--- core/fbs_dwell_timer.sv
/*
 * Free-running dwell timer: one-cycle tick every CYCLES clocks,
 * restarted by i_restart. Assumes synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module fbs_dwell_timer #(
    parameter int CYCLES = 250000000
) (
    input  wire logic i_clk,      // Core clock
    input  wire logic i_rst,      // Sync reset
    input  wire logic i_restart,  // Start a fresh dwell
    output logic      o_tick      // End of dwell pulse
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);
    logic [W-1:0] count;

    // Dwell counter, wraps at the last cycle
    always_ff @(posedge i_clk) begin
        if (i_rst || i_restart || count == LAST) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    assign o_tick = (count == LAST) && !i_restart;

    a_tick_spacing: assert property (@(posedge i_clk) disable iff (i_rst)
        o_tick |=> !o_tick) else $error("dwell tick repeated");
endmodule
`default_nettype wire

//--- core/fbs_host_writer.sv
/*
 * Writes the status word into the configured host data register
 * whenever it changes. Assumes the host accepts one write a cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module fbs_host_writer
    import fbs_pkg::*;
(
    input  wire logic                 i_clk,         // Core clock
    input  wire logic                 i_rst,         // Sync reset
    fbs_word_if.dst                   stat,          // Status word in
    input  wire logic                 i_reg_is_data, // Target is data type
    input  wire logic [REG_NUM_W-1:0] i_reg_num,     // Target register number
    output logic                      o_wr,          // Write strobe
    output logic [REG_NUM_W-1:0]      o_wr_num,      // Register number
    output logic [15:0]               o_wr_data,     // Written word
    output logic                      o_type_bad     // Target not data type
);
    logic [15:0] last;
    logic        sent;

    // Write on first valid word and on every change; never to
    // a non-data register, so a bad target simply stays silent
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_wr      <= 1'b0;
            o_wr_num  <= '0;
            o_wr_data <= STAT_RESET;
            last      <= STAT_RESET;
            sent      <= 1'b0;
        end else begin
            o_wr <= 1'b0;
            if (stat.valid && i_reg_is_data && (!sent || stat.word != last)) begin
                o_wr      <= 1'b1;
                o_wr_num  <= i_reg_num;
                o_wr_data <= stat.word;
                last      <= stat.word;
                sent      <= 1'b1;
            end
        end
    end

    // Configuration error flag for software visibility
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_type_bad <= 1'b0;
        end else begin
            o_type_bad <= !i_reg_is_data;
        end
    end

    a_write_data_only: assert property (@(posedge i_clk) disable iff (i_rst)
        o_wr |-> $past(i_reg_is_data)) else $error("write to non-data");
    c_host_write: cover property (@(posedge i_clk) disable iff (i_rst) o_wr);
endmodule
`default_nettype wire

//--- core/fbs_status_indicator.sv
/*
 * Fieldbus slave status indicator: run and link lamps, two-digit
 * hex display sequencing and the host status word.
 * Assumes all inputs synchronous to i_clk; reset marks power-up.
 */
// Functional notes
// - Run lamp green while host runs, off while host stopped.
// - Link lamp green when master traffic normal, red when not connected.
// - Normal display shows node address in range 01 to 7d hex.
// - Code 80 signals host stop.
// - Code f0 when node address outside 1 to 125.
// - Code f1 for internal hardware fault, f4 for I/O detect fault.
// - Code f2 for rejected parameters, f3 for rejected configuration.
// - Code f5 when factory test mode entered.
// - Code f6 when off network or not configured at this address.
// - Normal and running: display shows address only.
// - Normal and stopped: address alternates with 80.
// - Init or error and running: address, init code, error code.
// - Init or error and stopped: address, init code, 80.
// - Status high byte 00 when running, 80 when stopped.
// - Status low byte 00 when normal, else active fault code.
// - Status written only into configured host data register.
// - Addresses 01 to 7d valid; 00 and 7e to ff invalid.
// - Address switches sampled once after power-up only.
`timescale 1ns/1ps
`default_nettype none
module fbs_status_indicator
    import fbs_pkg::*;
#(
    parameter int DWELL = DWELL_CYCLES
) (
    input  wire logic                 i_clk,          // 250 MHz clock
    input  wire logic                 i_rst,          // Sync reset, power-up
    input  wire logic                 i_host_run,     // Host in run state
    input  wire logic                 i_link_ok,      // Master exchange normal
    input  wire logic                 i_net_attached, // Attached to network
    input  wire logic                 i_slave_cfg_ok, // Master set us up here
    input  wire logic                 i_init_busy,    // Module initializing
    input  wire logic                 i_hw_fault,     // Internal hardware fault
    input  wire logic                 i_io_fault,     // I/O detect fault
    input  wire logic                 i_factory_test, // Factory test mode
    input  wire logic                 i_param_reject, // Parameters rejected
    input  wire logic                 i_param_accept, // Parameters accepted
    input  wire logic                 i_cfg_reject,   // Configuration rejected
    input  wire logic                 i_cfg_accept,   // Configuration accepted
    input  wire logic [7:0]           i_addr_sw,      // Node address switches
    input  wire logic                 i_reg_is_data,  // Target is data type
    input  wire logic [REG_NUM_W-1:0] i_reg_num,      // Target register number
    output logic                      o_host_run_indicator,  // Run lamp green
    output logic                      o_link_indicator_green, // Link green
    output logic                      o_link_indicator_red,   // Link red
    output logic [7:0]                o_disp_code,    // Two hex digits
    output logic [15:0]               o_status_word,  // Status word copy
    output logic                      o_host_wr,      // Host write strobe
    output logic [REG_NUM_W-1:0]      o_host_wr_num,  // Host register number
    output logic [15:0]               o_host_wr_data, // Host write data
    output logic                      o_reg_type_bad  // Target not data type
);
    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic [7:0] node_addr;
    logic       addr_taken;
    logic       param_bad;
    logic       cfg_bad;
    logic [7:0] fault_code;
    logic [7:0] next_fault_code;
    logic       busy_mode;
    fbs_slot_t  slot;
    fbs_slot_t  next_slot;
    logic [7:0] next_disp;
    logic       tick;
    logic       mode_chg;
    logic [1:0] mode;
    logic [1:0] mode_q;
    logic [1:0] warm;

    fbs_word_if stat ();

    // ---------------------------------------------------------------
    // Address capture
    // ---------------------------------------------------------------
    // Switches read once after reset; later changes need a power cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            node_addr  <= 8'h00;
            addr_taken <= 1'b0;
        end else if (!addr_taken) begin
            node_addr  <= i_addr_sw;
            addr_taken <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Sticky master rejections
    // ---------------------------------------------------------------
    // A reject in the cycle of an accept wins, so it is never lost
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            param_bad <= 1'b0;
        end else if (i_param_reject) begin
            param_bad <= 1'b1;
        end else if (i_param_accept) begin
            param_bad <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cfg_bad <= 1'b0;
        end else if (i_cfg_reject) begin
            cfg_bad <= 1'b1;
        end else if (i_cfg_accept) begin
            cfg_bad <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Fault selection
    // ---------------------------------------------------------------
    // Priority: address, factory test, hardware, I/O, params, config,
    // network; a bad address masks every other fault code
    always_comb begin
        if (!fbs_addr_ok(node_addr)) begin
            next_fault_code = CODE_ADDRESS_OUT_OF_RANGE;
        end else if (i_factory_test) begin
            next_fault_code = CODE_FACTORY_TEST;
        end else if (i_hw_fault) begin
            next_fault_code = CODE_INTERNAL_HW_FAULT;
        end else if (i_io_fault) begin
            next_fault_code = CODE_IO_DETECT_FAULT;
        end else if (param_bad) begin
            next_fault_code = CODE_PARAMETER_FAULT;
        end else if (cfg_bad) begin
            next_fault_code = CODE_CONFIGURATION_FAULT;
        end else if (!i_net_attached || !i_slave_cfg_ok) begin
            next_fault_code = CODE_NOT_ON_NETWORK;
        end else begin
            next_fault_code = CODE_NONE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            fault_code <= CODE_NONE;
        end else if (addr_taken) begin
            fault_code <= next_fault_code;
        end
    end

    // ---------------------------------------------------------------
    // Lamps
    // ---------------------------------------------------------------
    // Link colours are exclusive so the lamp never shows amber
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_host_run_indicator   <= 1'b0;
            o_link_indicator_green <= 1'b0;
            o_link_indicator_red   <= 1'b0;
        end else begin
            o_host_run_indicator   <= i_host_run;
            o_link_indicator_green <= i_link_ok;
            o_link_indicator_red   <= !i_link_ok;
        end
    end

    // ---------------------------------------------------------------
    // Display sequencing
    // ---------------------------------------------------------------
    assign busy_mode = i_init_busy || (fault_code != CODE_NONE);
    assign mode      = {busy_mode, i_host_run};
    assign mode_chg  = (mode != mode_q);

    // Mode memory so a mode change restarts the sequence cleanly
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode_q <= 2'b01;
        end else begin
            mode_q <= mode;
        end
    end

    fbs_dwell_timer #(
        .CYCLES   (DWELL)
    ) u_dwell (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_restart(mode_chg),
        .o_tick   (tick)
    );

    // Slot walk: address only when normal and running
    always_comb begin
        next_slot = slot;
        if (mode_chg || (!busy_mode && i_host_run)) begin
            next_slot = SLOT_ADDR;
        end else if (tick) begin
            unique case (slot)
                SLOT_ADDR:   next_slot = SLOT_SECOND;
                SLOT_SECOND: next_slot = busy_mode ? SLOT_THIRD : SLOT_ADDR;
                SLOT_THIRD:  next_slot = SLOT_ADDR;
                default:     next_slot = SLOT_ADDR;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            slot <= SLOT_ADDR;
        end else begin
            slot <= next_slot;
        end
    end

    // Value shown for each slot
    always_comb begin
        unique case (slot)
            SLOT_ADDR:   next_disp = node_addr;
            SLOT_SECOND: next_disp = busy_mode ? CODE_INIT : CODE_HOST_STOP;
            SLOT_THIRD:  next_disp = i_host_run ? fault_code : CODE_HOST_STOP;
            default:     next_disp = node_addr;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_disp_code <= 8'h00;
        end else begin
            o_disp_code <= next_disp;
        end
    end

    // ---------------------------------------------------------------
    // Status word
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_status_word <= STAT_RESET;
        end else begin
            o_status_word[15:STAT_HI_LSB] <= i_host_run ? STAT_HI_RUN
                                                        : CODE_HOST_STOP;
            o_status_word[STAT_HI_LSB-1:0] <= (fault_code == CODE_NONE)
                ? STAT_LO_NORMAL : fault_code;
        end
    end

    // Writes held back two cycles after capture until the fault code
    // has reached the word, so the host never sees a false normal byte
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            warm <= 2'b00;
        end else begin
            warm <= {warm[0], addr_taken};
        end
    end

    assign stat.word  = o_status_word;
    assign stat.valid = warm[1];

    fbs_host_writer u_writer (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .stat         (stat),
        .i_reg_is_data(i_reg_is_data),
        .i_reg_num    (i_reg_num),
        .o_wr         (o_host_wr),
        .o_wr_num     (o_host_wr_num),
        .o_wr_data    (o_host_wr_data),
        .o_type_bad   (o_reg_type_bad)
    );

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_run_lamp: assert property (
        !$past(i_rst) |-> o_host_run_indicator == $past(i_host_run))
        else $error("run lamp wrong");
    a_link_lamp: assert property (
        !i_link_ok |=> o_link_indicator_red && !o_link_indicator_green)
        else $error("link lamp not red");
    a_addr_range: assert property (
        addr_taken && (node_addr == 8'h00 || node_addr > 8'h7d)
        |=> fault_code == 8'hf0) else $error("bad address not flagged");
    a_addr_frozen: assert property (
        addr_taken |=> $stable(node_addr)) else $error("address changed");
    a_factory_code: assert property (
        addr_taken && fbs_addr_ok(node_addr) && i_factory_test
        |=> fault_code == 8'hf5) else $error("factory code missing");
    a_hw_code: assert property (
        addr_taken && fbs_addr_ok(node_addr) && !i_factory_test && i_hw_fault
        |=> fault_code == 8'hf1) else $error("hw fault code missing");
    a_param_code: assert property (
        i_param_reject && addr_taken && fbs_addr_ok(node_addr)
        && !i_factory_test && !i_hw_fault && !i_io_fault
        ##1 (!i_factory_test && !i_hw_fault && !i_io_fault)
        |=> fault_code == 8'hf2) else $error("param code missing");
    a_net_code: assert property (
        addr_taken && fbs_addr_ok(node_addr) && next_fault_code != 8'hf0
        && !i_net_attached && !i_factory_test && !i_hw_fault && !i_io_fault
        && !param_bad && !cfg_bad |=> fault_code == 8'hf6)
        else $error("network code missing");
    a_run_addr_only: assert property (
        (!busy_mode && i_host_run)[*3] |-> o_disp_code == node_addr)
        else $error("run display not address");
    a_stop_shows_80: assert property (
        !busy_mode && !i_host_run && !mode_chg && slot == SLOT_ADDR && tick
        ##1 (!busy_mode && !i_host_run && !mode_chg) |=> o_disp_code == 8'h80)
        else $error("stop code not shown");
    a_third_value: assert property (
        slot == SLOT_THIRD ##1 (i_host_run == $past(i_host_run))
        |-> o_disp_code == ($past(i_host_run) ? $past(fault_code) : 8'h80))
        else $error("third value wrong");
    a_status_bytes: assert property (
        !i_host_run && fault_code == 8'h00 |=> o_status_word == 16'h8000)
        else $error("status word wrong");
    a_link_green: assert property (
        i_link_ok |=> o_link_indicator_green && !o_link_indicator_red)
        else $error("link lamp not green");
    a_io_code: assert property (
        addr_taken && fbs_addr_ok(node_addr) && !i_factory_test && !i_hw_fault
        && i_io_fault |=> fault_code == 8'hf4) else $error("io fault code missing");
    a_cfg_code: assert property (
        i_cfg_reject && addr_taken && fbs_addr_ok(node_addr) && !i_factory_test
        && !i_hw_fault && !i_io_fault && !param_bad
        ##1 (!i_factory_test && !i_hw_fault && !i_io_fault && !param_bad)
        |=> fault_code == 8'hf3) else $error("config code missing");
    a_init_code: assert property (
        busy_mode && slot == SLOT_SECOND |=> o_disp_code == 8'hc0)
        else $error("init code not shown");
    a_stop_third: assert property (
        busy_mode && !i_host_run && slot == SLOT_THIRD |=> o_disp_code == 8'h80)
        else $error("stop code not third");
    a_status_hi_run: assert property (
        i_host_run |=> o_status_word[15:8] == 8'h00) else $error("status high byte wrong");
    a_status_lo_fault: assert property (
        fault_code != 8'h00 |=> o_status_word[7:0] == $past(fault_code))
        else $error("status low byte wrong");

    c_stop_alternate: cover property (
        !busy_mode && !i_host_run && slot == SLOT_SECOND);
    c_error_third: cover property (busy_mode && i_host_run && slot == SLOT_THIRD);
    c_param_fault: cover property (fault_code == 8'hf2);
    c_init_only: cover property (i_init_busy && fault_code == 8'h00 && slot == SLOT_THIRD);
endmodule
`default_nettype wire

//--- tb/fbs_host_model.sv
/*
 * Host CPU model: a data register area written by the status strobe.
 * Assumes writes arrive as one-cycle strobes sampled on i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module fbs_host_model (
    input  wire logic        i_clk,   // Core clock
    input  wire logic        i_wr,    // Write strobe
    input  wire logic [15:0] i_num,   // Register number
    input  wire logic [15:0] i_data,  // Word written
    output var  logic [15:0] o_word,  // Last word stored
    output var  logic [15:0] o_num,   // Where it went
    output var  int          o_count  // Writes taken
);
    // ------------------------------------------------------------
    // Register area
    // ------------------------------------------------------------
    // Keep the last write and its register number, and count all writes
    initial begin
        o_word = 16'h0000;
        o_num = 16'h0000;
        o_count = 0;
    end
    always @(posedge i_clk) begin
        if (i_wr === 1'b1) begin
            o_word <= i_data;
            o_num <= i_num;
            o_count <= o_count + 1;
        end
    end
endmodule
`default_nettype wire

//--- tb/fbs_status_indicator_tb_top.sv
/*
 * Self-checking bench for the status indicator with a host model.
 * Assumes DWELL is shortened to 8 cycles; inputs move 1 ns after edges.
 */
`timescale 1ns/1ps
`default_nettype none
module fbs_status_indicator_tb_top;
    import fbs_pkg::*;
    localparam int DW = 8;
    logic i_clk = 0, i_rst = 1, run = 1, link = 1, att = 1, cfg = 1, busy = 0;
    logic hw = 0, io = 0, ft = 0, pr = 0, pa = 0, cr = 0, ca = 0, isd = 1;
    logic [7:0] addr = 8'h1a, cap, d;
    logic [15:0] rnum = 16'h00c8, word, wnum, wdata, mword, mnum;
    logic host_run_indicator, grn, red, wr, tbad, p_st, c_st;
    int n_errors = 0, samples_checked = 0, cyc = 0, mcnt, oth, k, c0;
    always #2 i_clk = ~i_clk;
    fbs_status_indicator #(.DWELL(DW)) fbs_status_indicator_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_host_run(run), .i_link_ok(link),
        .i_net_attached(att), .i_slave_cfg_ok(cfg), .i_init_busy(busy),
        .i_hw_fault(hw), .i_io_fault(io), .i_factory_test(ft),
        .i_param_reject(pr), .i_param_accept(pa), .i_cfg_reject(cr),
        .i_cfg_accept(ca), .i_addr_sw(addr), .i_reg_is_data(isd),
        .i_reg_num(rnum), .o_host_run_indicator(host_run_indicator),
        .o_link_indicator_green(grn), .o_link_indicator_red(red),
        .o_disp_code(d), .o_status_word(word), .o_host_wr(wr),
        .o_host_wr_num(wnum), .o_host_wr_data(wdata), .o_reg_type_bad(tbad));
    fbs_host_model fbs_host_model_i (.i_clk(i_clk), .i_wr(wr), .i_num(wnum),
        .i_data(wdata), .o_word(mword), .o_num(mnum), .o_count(mcnt));
    // ------------------------------------------------------------
    // Reference model and helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Fault priority as the reference sees it, from bench-held state
    function automatic logic [15:0] exp_word();
        int lo;
        lo = (cap < 8'h01 || cap > 8'h7d) ? 'hf0 : ft ? 'hf5 : hw ? 'hf1 : io ? 'hf4
           : p_st ? 'hf2 : c_st ? 'hf3 : (!att || !cfg) ? 'hf6 : 0;
        return {(run ? 8'h00 : 8'h80), lo[7:0]};
    endfunction
    task automatic power(input logic [7:0] a);
        i_rst = 1;
        addr = a;
        cap = a;
        p_st = 0;
        c_st = 0;
        step(4);
        i_rst = 0;
        step(8);
    endtask
    // Count codes outside the expected set over a full sequence
    task automatic watch(input logic [7:0] a, b, c);
        oth = 0;
        c0 = 0;
        repeat (3 * DW + 6) begin
            step(1);
            if (d !== a && d !== b && d !== c) oth++;
            if (d === c) c0++;
        end
        check(oth, 0);
        check(c0 > 0, 1);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h515907c2));
        power(8'h1a);
        addr = 8'h33;
        step(4);
        check(d, 8'h1a);
        check(word, exp_word());
        check(mword, word);
        check(mnum, rnum);
        check(mcnt, 1);
        $display("test address done");
        // Lamps follow random host and link states
        repeat (20) begin
            run = $urandom;
            link = $urandom;
            step(2);
            check(host_run_indicator, run);
            check({grn, red}, {link, !link});
            check(word, exp_word());
        end
        run = 1;
        $display("test lamps done");
        // Each fault source other than the address alone, then sticky rejects cleared
        for (k = 0; k < 7; k++) begin
            {ft, hw, io, att, cfg} = {k == 0, k == 1, k == 2, k != 5, k != 6};
            {pr, cr} = {k == 3, k == 4};
            p_st = (k == 3);
            c_st = (k == 4);
            step(1);
            {pr, cr} = 2'b00;
            step(4);
            check(word, exp_word());
            check(mword, word);
            {pa, ca} = {k == 3, k == 4};
            p_st = 0;
            c_st = 0;
            step(1);
            {pa, ca} = 2'b00;
            {ft, hw, io, att, cfg} = 5'b00011;
            step(4);
            check(word, exp_word());
        end
        $display("test faults done");
        // Display sequences in the four module and host states
        watch(8'h1a, 8'h1a, 8'h1a);
        run = 0;
        watch(8'h1a, 8'h1a, 8'h80);
        hw = 1;
        watch(8'h1a, 8'hc0, 8'h80);
        run = 1;
        watch(8'h1a, 8'hc0, 8'hf1);
        hw = 0;
        busy = 1;
        step(2);
        watch(8'h1a, 8'hc0, 8'h00);
        check(word, exp_word());
        busy = 0;
        $display("test display done");
        // Non-data target refused, pending word written later
        isd = 0;
        k = mcnt;
        run = 0;
        step(5);
        check(tbad, 1);
        check(mcnt, k);
        isd = 1;
        step(5);
        check(mword, exp_word());
        run = 1;
        $display("test target done");
        // Addresses at both edges of the range: 00 and 7e invalid, 7d valid
        power(8'h00);
        check(word, exp_word());
        power(8'h7e);
        check(word, exp_word());
        power(8'h7d);
        check(word, exp_word());
        $display("test range done");
        stop_test();
    end
endmodule
`default_nettype wire
